// file: logic/command_status_page_regs.sv
// page-0 registers: page select, command control, communication interrupt enable
// assumes host-interface logic presents decoded, synchronous register strobes
// Operation
// - page override on: page number forms address bits 5 and 4
// - page override off: internal latch alone forms the whole address
// - page number ignored while page override is clear
// - command register resets to 20h
// - receiver off bit drives analog receiver power-down output
// - writing 1 to sleep bit enters soft power-down
// - writing 0 starts wake-up; bit reads 1 until wake-up completes
// - sleep bit cannot be set while soft restart command runs
// - host writes command code; read returns currently executing command
// - command engine returns command field to idle on completion
// - invert bit selects interrupt pin polarity against combined flag
// - enable register resets to 80h, pin released after reset when open-drain (push-pull drives it high)
// - drive style selects push-pull or open-drain interrupt pin
// - each communication request reaches the pin only while its enable is set; misc request is not gated
// - reserved bits read zero
module command_status_page_regs
  import cmd_page_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // register access
  input  wire logic [5:0] i_latch_addr,
  input  wire logic [3:0] i_pin_addr,
  input  wire logic       i_use_pins,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  output logic      [5:0] o_reg_addr,
  output logic      [7:0] o_rdata,
  // command engine
  input  wire logic       i_cmd_done,
  input  wire logic       i_wake_done,
  output logic      [3:0] o_command,
  output logic            o_cmd_start,
  output logic            o_soft_sleep,
  output logic            o_rcv_off,
  // interrupt requests and pin
  input  wire logic [6:0] i_comm_req,
  input  wire logic       i_misc_irq,
  input  wire logic       i_push_pull,
  output logic            o_combined_irq,
  output logic            o_irq_out,
  output logic            o_irq_oe_n
);
  import cmd_page_pkg::*;

  logic [7:0] page_q, page_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] ien_q, ien_d;
  logic       sleep_req_q, sleep_req_d;
  logic       start_q, start_d;
  logic       irq_q, irq_d;
  logic [5:0] addr_low;

  // lower address bits from pins or latch
  assign addr_low = i_use_pins ? {2'b00, i_pin_addr} : i_latch_addr;

  // address formation
  always_comb
  begin
    if (page_q[PAGE_OVR_BIT])
      o_reg_addr = {page_q[1:0], addr_low[3:0]};
    else
      o_reg_addr = i_latch_addr;
  end

  // next register values
  always_comb
  begin
    page_d      = page_q;
    cmd_d       = cmd_q;
    ien_d       = ien_q;
    sleep_req_d = sleep_req_q;
    start_d     = 1'b0;
    if (i_cmd_done)
      cmd_d[3:0] = CMD_IDLE;
    // wake-up done clears the reported bit
    if (!sleep_req_q && i_wake_done)
      cmd_d[SLEEP_BIT] = 1'b0;
    if (i_wr)
    begin
      case (o_reg_addr[3:0])
        PAGE_SEL_ADDR[3:0]: page_d = i_wdata & PAGE_SEL_MASK;
        CMD_CTRL_ADDR[3:0]:
        begin
          cmd_d[RCV_OFF_BIT] = i_wdata[RCV_OFF_BIT];
          cmd_d[3:0] = i_wdata[3:0];
          start_d    = 1'b1;
          if (i_wdata[SLEEP_BIT] && cmd_q[3:0] != CMD_SOFT_RESTART)
          begin
            sleep_req_d      = 1'b1;
            cmd_d[SLEEP_BIT] = 1'b1;
          end
          else if (!i_wdata[SLEEP_BIT])
            // wake-up starts, bit held until done
            sleep_req_d = 1'b0;
        end
        COMM_IEN_ADDR[3:0]: ien_d = i_wdata;
        default: ;
      endcase
    end
    cmd_d = cmd_d & CMD_CTRL_MASK;
  end

  assign irq_d = (|(i_comm_req & ien_q[6:0])) | i_misc_irq;

  // register state
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      page_q      <= PAGE_SEL_RST;
      cmd_q       <= CMD_CTRL_RST;
      ien_q       <= COMM_IEN_RST;
      sleep_req_q <= 1'b0;
      start_q     <= 1'b0;
      irq_q       <= 1'b0;
    end
    else
    begin
      page_q      <= page_d;
      cmd_q       <= cmd_d;
      ien_q       <= ien_d;
      sleep_req_q <= sleep_req_d;
      start_q     <= start_d;
      irq_q       <= irq_d;
    end
  end

  // readback; reserved bits are zero by mask
  always_comb
  begin
    case (o_reg_addr[3:0])
      PAGE_SEL_ADDR[3:0]: o_rdata = page_q;
      CMD_CTRL_ADDR[3:0]: o_rdata = cmd_q;
      COMM_IEN_ADDR[3:0]: o_rdata = ien_q;
      default:            o_rdata = 8'h00;
    endcase
  end

  assign o_command    = cmd_q[3:0];
  assign o_cmd_start  = start_q;
  assign o_soft_sleep = sleep_req_q;
  assign o_rcv_off    = cmd_q[RCV_OFF_BIT];
  assign o_combined_irq = irq_q;

  // pin drive; open-drain only pulls low, so idle-high with invert gives released
  always_comb
  begin
    o_irq_out = irq_q ^ ien_q[IRQ_INV_BIT];
    if (i_push_pull)
      o_irq_oe_n = 1'b0;
    else
      o_irq_oe_n = o_irq_out;
  end

  a_irq_polarity: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_irq_out == (o_combined_irq ^ ien_q[IRQ_INV_BIT]))
    else $error("irq pin polarity wrong");
  a_sleep_refused: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_wr && o_reg_addr[3:0] == 4'h1 && cmd_q[3:0] == CMD_SOFT_RESTART && !sleep_req_q)
    |=> !sleep_req_q)
    else $error("sleep set during restart");
  a_wake_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($fell(sleep_req_q) && !i_wake_done) |-> cmd_q[SLEEP_BIT])
    else $error("sleep bit dropped early");
  a_rcv_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_rcv_off == o_rdata[RCV_OFF_BIT] || o_reg_addr[3:0] != 4'h1)
    else $error("receiver off mismatch");
  a_gate_req: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!(|(i_comm_req & ien_q[6:0])) && !i_misc_irq && ien_q == $past(ien_q)) |=> !irq_q)
    else $error("ungated request reached flag");
  a_page_addr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    page_q[PAGE_OVR_BIT] |-> o_reg_addr[5:4] == page_q[1:0])
    else $error("page bits not applied");
  a_cmd_rsvd: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmd_q[7:6] == 2'b00 && page_q[6:2] == 5'h00)
    else $error("reserved bits nonzero");
  a_sleep_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_wr && o_reg_addr[3:0] == 4'h1 && i_wdata[SLEEP_BIT] && cmd_q[3:0] != CMD_SOFT_RESTART)
    |=> (sleep_req_q && cmd_q[SLEEP_BIT]))
    else $error("sleep write not taken");
  // wake done clears the reported bit
  a_wake_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!sleep_req_q && i_wake_done && !i_wr) |=> !cmd_q[SLEEP_BIT])
    else $error("sleep bit kept after wake");
  // engine completion returns field to idle
  a_cmd_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cmd_done && !i_wr) |=> cmd_q[3:0] == CMD_IDLE)
    else $error("command field not idle");
  a_irq_drive: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_push_pull |-> !o_irq_oe_n)
    else $error("push-pull pin not driven");
  a_reset_vals: assert property (@(posedge i_clk)
    $past(!i_nrst) |-> cmd_q == 8'h20 && ien_q == 8'h80)
    else $error("reset values wrong");
endmodule

// file: logic/cmd_page_pkg.sv
// shared constants for the page-0 command and status register bank
// assumes a simple internal register strobe interface from the host-interface logic
package cmd_page_pkg;
  // register offsets within a page
  localparam logic [5:0] PAGE_SEL_ADDR = 6'h00;
  localparam logic [5:0] CMD_CTRL_ADDR = 6'h01;
  localparam logic [5:0] COMM_IEN_ADDR = 6'h02;
  // reset values
  localparam logic [7:0] PAGE_SEL_RST  = 8'h00;
  localparam logic [7:0] CMD_CTRL_RST  = 8'h20;
  localparam logic [7:0] COMM_IEN_RST  = 8'h80;
  // field positions
  localparam int PAGE_OVR_BIT  = 7;
  localparam int RCV_OFF_BIT   = 5;
  localparam int SLEEP_BIT     = 4;
  localparam int IRQ_INV_BIT   = 7;
  // writable masks; other bits are reserved and read zero
  localparam logic [7:0] PAGE_SEL_MASK = 8'h83;
  localparam logic [7:0] CMD_CTRL_MASK = 8'h3f;
  // command codes
  localparam logic [3:0] CMD_IDLE         = 4'h0;
  localparam logic [3:0] CMD_SOFT_RESTART = 4'hf;
endpackage

// file: tb/engine_model.sv
// stand-in for the command engine beside the register bank
// assumes start and sleep arrive registered on the same clock
module engine_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // from the bank and the bench
  input  wire logic i_start,
  input  wire logic i_sleep,
  input  wire logic i_stall,
  // completion pulses
  output logic      o_done,
  output logic      o_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q;
  logic       slp_q;
  logic [2:0] wk_q;
  // stall keeps a command running, as a long restart would
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      cnt_q <= 3'h0;
      slp_q <= 1'b0;
      wk_q  <= 3'h0;
    end
    else
    begin
      slp_q <= i_sleep;
      wk_q  <= {wk_q[1:0], slp_q & !i_sleep};
      if (i_start)
        cnt_q <= 3'h4;
      else if (cnt_q != 3'h0 && !i_stall)
        cnt_q <= cnt_q - 3'h1;
    end
  end
  assign o_done = (cnt_q == 3'h1) && !i_stall;
  assign o_wake = wk_q[2];
endmodule

// file: tb/tb_command_status_page_regs.sv
// register-level bench for the page-0 command and status bank
// assumes the engine stand-in answers starts and wake-ups
module tb_command_status_page_regs;
  import cmd_page_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clk = 1'b0, i_nrst = 1'b0, i_use_pins = 1'b0, i_wr = 1'b0;
  logic       i_misc_irq = 1'b0, i_push_pull = 1'b0, stall = 1'b0;
  logic       done, wake, cmd_start, soft_sleep, rcv_off, comb, irq_out, oe_n;
  logic [5:0] latch = 6'h00, reg_addr;
  logic [3:0] i_pin_addr = 4'h0, command;
  logic [7:0] i_wdata = 8'h00, rdata;
  logic [6:0] i_comm_req = 7'h00;
  int         mismatches = 0, comparisons = 0;
  always #20 i_clk = ~i_clk;
  command_status_page_regs command_status_page_regs_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_latch_addr(latch), .i_pin_addr(i_pin_addr), .i_use_pins(i_use_pins), .i_wr(i_wr),
    .i_wdata(i_wdata), .o_reg_addr(reg_addr), .o_rdata(rdata), .i_cmd_done(done),
    .i_wake_done(wake), .o_command(command), .o_cmd_start(cmd_start),
    .o_soft_sleep(soft_sleep), .o_rcv_off(rcv_off), .i_comm_req(i_comm_req),
    .i_misc_irq(i_misc_irq), .i_push_pull(i_push_pull), .o_combined_irq(comb),
    .o_irq_out(irq_out), .o_irq_oe_n(oe_n));
  engine_model engine_model_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_start(cmd_start),
    .i_sleep(soft_sleep), .i_stall(stall), .o_done(done), .o_wake(wake));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // one write strobe, released a cycle later
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_clk);
    latch = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_clk);
    i_wr = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    latch = a;
    #1 chk("rdata", rdata, e);
  endtask
  task automatic close_out;
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog: the tests need well under ten microseconds
  initial
  begin
    #50000;
    mismatches++;
    close_out;
  end
  initial
  begin
    int i;
    cyc(3);
    i_nrst = 1'b1;
    rd(6'h00, 8'h00);
    rd(6'h01, 8'h20);
    rd(6'h02, 8'h80);
    chk("rcv_off", {7'h0, rcv_off}, 8'h01);
    chk("oe_n", {7'h0, oe_n}, 8'h01);
    wr(6'h00, 8'hff);
    rd(6'h00, 8'h83);
    wr(6'h00, 8'h81);
    i_use_pins = 1'b1;
    i_pin_addr = 4'h5;
    latch = 6'h3a;
    #1 chk("addr", {2'h0, reg_addr}, 8'h15);
    i_use_pins = 1'b0;
    #1 chk("addr", {2'h0, reg_addr}, 8'h1a);
    wr(6'h00, 8'h02);
    latch = 6'h3a;
    #1 chk("addr", {2'h0, reg_addr}, 8'h3a);
    // command runs, then the engine returns it to idle
    wr(6'h01, 8'h0c);
    rd(6'h01, 8'h0c);
    chk("command", {4'h0, command}, 8'h0c);
    chk("start", {7'h0, cmd_start}, 8'h01);
    chk("rcv_off", {7'h0, rcv_off}, 8'h00);
    cyc(6);
    rd(6'h01, 8'h00);
    wr(6'h01, 8'h10);
    chk("sleep", {7'h0, soft_sleep}, 8'h01);
    wr(6'h01, 8'h00);
    rd(6'h01, 8'h10);
    cyc(6);
    rd(6'h01, 8'h00);
    stall = 1'b1;
    wr(6'h01, 8'h0f);
    wr(6'h01, 8'h1f);
    rd(6'h01, 8'h0f);
    stall = 1'b0;
    cyc(6);
    rd(6'h01, 8'h00);
    // each communication request source against its own enable
    wr(6'h02, 8'h00);
    i_comm_req = 7'h7f;
    cyc(1);
    chk("comb", {7'h0, comb}, 8'h00);
    for (i = 0; i < 7; i++)
    begin
      wr(6'h02, 8'h01 << i);
      i_comm_req = 7'h01 << i;
      cyc(1);
      chk("comb", {7'h0, comb}, 8'h01);
      chk("irq_out", {7'h0, irq_out}, 8'h01);
      i_comm_req = ~(7'h01 << i);
      cyc(1);
      chk("comb", {7'h0, comb}, 8'h00);
    end
    i_comm_req = 7'h00;
    i_misc_irq = 1'b1;
    cyc(1);
    chk("comb", {7'h0, comb}, 8'h01);
    wr(6'h02, 8'h80);
    chk("irq_out", {7'h0, irq_out}, 8'h00);
    chk("oe_n", {7'h0, oe_n}, 8'h00);
    i_misc_irq = 1'b0;
    cyc(1);
    chk("oe_n", {7'h0, oe_n}, 8'h01);
    i_push_pull = 1'b1;
    #1 chk("oe_n", {7'h0, oe_n}, 8'h00);
    close_out;
  end
endmodule
